// file: mwm_top.v
// motion window monitor: following error, target position and target
// speed windows with millisecond persistence, register port access
// assumes one 10 MHz clock, synchronous inputs from the motion core
`include "mwm_defines.vh"
`timescale 1ns/1ps

module mwm_top
#(
  parameter TICK_CYCLES = `MWM_TICK_NS / `MWM_CLK_NS,
  parameter [15:0] ERR_CODE = 16'h8611
)
(
  input wire clock_i,
  input wire rst_i,
  input wire [15:0] addr_i,
  input wire [31:0] wr_data_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rd_data_o,
  input wire [31:0] pos_inc_i,
  input wire [31:0] pos_user_i,
  input wire [31:0] pos_demand_i,
  input wire [31:0] target_pos_i,
  input wire [31:0] speed_i,
  input wire [31:0] target_speed_i,
  input wire [31:0] ramp_speed_i,
  input wire homing_done_i,
  output reg [15:0] status_word_o,
  output reg err_log_o,
  output reg irq_o
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // magnitude of a signed difference; 33 bits so no wrap at extremes
  function [32:0] abs_diff;
    input [31:0] a;
    input [31:0] b;
    reg [32:0] d;
    begin
      d = {a[31], a} - {b[31], b};
      abs_diff = d[32] ? (~d + 33'd1) : d;
    end
  endfunction

  // persistence counter: clear on drop, saturating count of ms ticks
  function [16:0] tmr_next;
    input cond;
    input tick;
    input [16:0] cnt;
    begin
      if (!cond)
        tmr_next = 17'h00000;
      else if (tick && !cnt[16])
        tmr_next = cnt + 17'h00001;
      else
        tmr_next = cnt;
    end
  endfunction

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  reg [31:0] fe_tol;
  reg [15:0] fe_timeout;
  reg [31:0] tp_tol;
  reg [15:0] tp_dwell;
  reg [15:0] ts_tol;
  reg [15:0] ts_dwell;
  reg [7:0] mode;
  reg [15:0] reaction;
  reg [15:0] err_count;
  reg [15:0] err_last;
  reg [31:0] pos_inc;
  reg [31:0] pos_user;
  reg [31:0] home_ref;
  reg [31:0] spd_setpoint;
  reg [31:0] act_speed;
  reg [1:0] irq_status;
  reg [1:0] irq_enable;
  reg [13:0] tick_cnt;
  reg tick;
  reg [16:0] fe_cnt;
  reg [16:0] tp_cnt;
  reg [16:0] ts_cnt;
  reg fe_flag;
  reg tgt_flag;

  wire wr_hit_clear;
  wire fe_cond;
  wire tp_cond;
  wire ts_cond;
  wire pos_mode;
  wire next_fe_flag;
  wire next_tgt_flag;
  wire [1:0] irq_events;

  // ------------------------------------------------------------------
  // ms tick
  // ------------------------------------------------------------------
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tick_cnt <= 14'h0000;
      tick <= 1'b0;
    end
    else if (tick_cnt == TICK_CYCLES[13:0] - 14'h0001)
    begin
      tick_cnt <= 14'h0000;
      tick <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 14'h0001;
      tick <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------------
  assign wr_hit_clear = wr_i && (addr_i == `MWM_A_IRQ_CLEAR);

  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fe_tol <= `MWM_R_FE_TOL;
      fe_timeout <= `MWM_R_FE_TIMEOUT;
      tp_tol <= `MWM_R_TP_TOL;
      tp_dwell <= `MWM_R_TP_DWELL;
      ts_tol <= `MWM_R_TS_TOL;
      ts_dwell <= `MWM_R_TS_DWELL;
      mode <= `MWM_R_MODE;
      reaction <= `MWM_R_REACTION;
      irq_enable <= 2'h0;
    end
    else if (wr_i)
    begin
      case (addr_i)
        `MWM_A_FE_TOL: fe_tol <= wr_data_i;
        `MWM_A_FE_TIMEOUT: fe_timeout <= wr_data_i[15:0];
        `MWM_A_TP_TOL: tp_tol <= wr_data_i;
        `MWM_A_TP_DWELL: tp_dwell <= wr_data_i[15:0];
        `MWM_A_TS_TOL: ts_tol <= wr_data_i[15:0];
        `MWM_A_TS_DWELL: ts_dwell <= wr_data_i[15:0];
        `MWM_A_MODE: mode <= wr_data_i[7:0];
        `MWM_A_REACTION: reaction <= wr_data_i[15:0];
        `MWM_A_IRQ_ENABLE: irq_enable <= wr_data_i[1:0];
        default: irq_enable <= irq_enable;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // actual values
  // ------------------------------------------------------------------
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pos_inc <= 32'h00000000;
      pos_user <= 32'h00000000;
      home_ref <= 32'h00000000;
      spd_setpoint <= 32'h00000000;
      act_speed <= 32'h00000000;
    end
    else
    begin
      pos_inc <= pos_inc_i;
      if (homing_done_i)
      begin
        home_ref <= pos_user_i;
        pos_user <= 32'h00000000;
      end
      else
        pos_user <= pos_user_i - home_ref;
      spd_setpoint <= ramp_speed_i;
      act_speed <= speed_i;
    end
  end

  // ------------------------------------------------------------------
  // window conditions
  // ------------------------------------------------------------------
  // following error uses the rebased user position, as software sees it
  // sentinel gates the monitor
  assign fe_cond = (fe_tol != `MWM_FE_OFF) &&
    (abs_diff(pos_user, pos_demand_i) > {1'b0, fe_tol});

  assign pos_mode = (mode == `MWM_MODE_PP) || (mode == `MWM_MODE_IP);

  assign tp_cond = pos_mode && (tp_tol != `MWM_TP_OFF) &&
    (abs_diff(pos_user, target_pos_i) < {1'b0, tp_tol});

  assign ts_cond = (mode == `MWM_MODE_PV) &&
    (abs_diff(act_speed, target_speed_i) < {17'h00000, ts_tol});

  // ------------------------------------------------------------------
  // persistence timers
  // ------------------------------------------------------------------
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fe_cnt <= 17'h00000;
      tp_cnt <= 17'h00000;
      ts_cnt <= 17'h00000;
    end
    else
    begin
      fe_cnt <= tmr_next(fe_cond, tick, fe_cnt);
      tp_cnt <= tmr_next(tp_cond, tick, tp_cnt);
      ts_cnt <= tmr_next(ts_cond, tick, ts_cnt);
    end
  end

  assign next_fe_flag = fe_cond && (fe_cnt > {1'b0, fe_timeout});
  assign next_tgt_flag = (tp_cond && (tp_cnt > {1'b0, tp_dwell})) ||
    (ts_cond && (ts_cnt > {1'b0, ts_dwell}));

  // ------------------------------------------------------------------
  // status word, error history, interrupt
  // ------------------------------------------------------------------
  assign irq_events = {next_tgt_flag & ~tgt_flag,
    next_fe_flag & ~fe_flag};

  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fe_flag <= 1'b0;
      tgt_flag <= 1'b0;
      status_word_o <= 16'h0000;
      err_count <= 16'h0000;
      err_last <= 16'h0000;
      err_log_o <= 1'b0;
      irq_status <= 2'h0;
      irq_o <= 1'b0;
    end
    else
    begin
      fe_flag <= next_fe_flag;
      tgt_flag <= next_tgt_flag;
      status_word_o <= 16'h0000;
      status_word_o[`MWM_SW_FOLLOW] <= next_fe_flag;
      status_word_o[`MWM_SW_TARGET] <= next_tgt_flag;
      // log only with a reaction set
      err_log_o <= irq_events[`MWM_IRQ_FOLLOW] && (reaction != 16'h0000);
      if (irq_events[`MWM_IRQ_FOLLOW] && (reaction != 16'h0000))
      begin
        err_count <= err_count + 16'h0001;
        err_last <= ERR_CODE;
      end
      // new events win over a clear in the same cycle
      irq_status <= irq_events |
        (irq_status & ~(wr_hit_clear ? wr_data_i[1:0] : 2'h0));
      irq_o <= |(irq_status & irq_enable);
    end
  end

  // ------------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------------
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      rd_data_o <= 32'h00000000;
    else if (rd_i)
    begin
      case (addr_i)
        `MWM_A_ERR_HIST: rd_data_o <= {err_last, err_count};
        `MWM_A_REACTION: rd_data_o <= {16'h0000, reaction};
        `MWM_A_STATUS_WORD: rd_data_o <= {16'h0000, status_word_o};
        `MWM_A_MODE: rd_data_o <= {24'h000000, mode};
        `MWM_A_POS_INC: rd_data_o <= pos_inc;
        `MWM_A_POS_USER: rd_data_o <= pos_user;
        `MWM_A_FE_TOL: rd_data_o <= fe_tol;
        `MWM_A_FE_TIMEOUT: rd_data_o <= {16'h0000, fe_timeout};
        `MWM_A_TP_TOL: rd_data_o <= tp_tol;
        `MWM_A_TP_DWELL: rd_data_o <= {16'h0000, tp_dwell};
        `MWM_A_SPD_SETPOINT: rd_data_o <= spd_setpoint;
        `MWM_A_ACT_SPEED: rd_data_o <= act_speed;
        `MWM_A_TS_TOL: rd_data_o <= {16'h0000, ts_tol};
        `MWM_A_TS_DWELL: rd_data_o <= {16'h0000, ts_dwell};
        `MWM_A_IRQ_STATUS: rd_data_o <= {30'h00000000, irq_status};
        `MWM_A_IRQ_ENABLE: rd_data_o <= {30'h00000000, irq_enable};
        // unmapped and write-only addresses read zero
        default: rd_data_o <= 32'h00000000;
      endcase
    end
    else
      rd_data_o <= 32'h00000000;
  end

endmodule

// file: mwm_defines.vh
// register offsets, reset values, field positions and timing constants
// for the motion window monitor; definitions only
`ifndef MWM_DEFINES_VH
`define MWM_DEFINES_VH

// register offsets (16-bit register address)
`define MWM_A_ERR_HIST      16'h1003
`define MWM_A_REACTION      16'h3700
`define MWM_A_STATUS_WORD   16'h6041
`define MWM_A_MODE          16'h6060
`define MWM_A_POS_INC       16'h6063
`define MWM_A_POS_USER      16'h6064
`define MWM_A_FE_TOL        16'h6065
`define MWM_A_FE_TIMEOUT    16'h6066
`define MWM_A_TP_TOL        16'h6067
`define MWM_A_TP_DWELL      16'h6068
`define MWM_A_SPD_SETPOINT  16'h606b
`define MWM_A_ACT_SPEED     16'h606c
`define MWM_A_TS_TOL        16'h606d
`define MWM_A_TS_DWELL      16'h606e
`define MWM_A_IRQ_STATUS    16'h7000
`define MWM_A_IRQ_CLEAR     16'h7001
`define MWM_A_IRQ_ENABLE    16'h7002

// reset values
`define MWM_R_FE_TOL        32'h00000100
`define MWM_R_FE_TIMEOUT    16'h0064
`define MWM_R_TP_TOL        32'h0000000a
`define MWM_R_TP_DWELL      16'h0064
`define MWM_R_TS_TOL        16'h001e
`define MWM_R_TS_DWELL      16'h0000
`define MWM_R_MODE          8'h00
`define MWM_R_REACTION      16'h0000

// monitoring-off sentinels
`define MWM_FE_OFF          32'hffffffff
`define MWM_TP_OFF          32'h0fffffff

// operating modes
`define MWM_MODE_PP         8'h01
`define MWM_MODE_PV         8'h03
`define MWM_MODE_IP         8'h07

// status word bits
`define MWM_SW_TARGET       10
`define MWM_SW_FOLLOW       13

// interrupt bits
`define MWM_IRQ_FOLLOW      0
`define MWM_IRQ_TARGET      1

// timing: 1 ms tick from a 100 ns clock
`define MWM_TICK_NS         1000000
`define MWM_CLK_NS          100

`endif

// file: mwm_master.sv
// fieldbus master model: register reads and writes on the plain port
// assumes callers enter its tasks just after a rising clock edge
`timescale 1ns/1ps
module mwm_master
(
  input wire clock_i,
  input wire [31:0] rd_data_i,
  output reg [15:0] addr_o,
  output reg [31:0] wr_data_o,
  output reg wr_o,
  output reg rd_o
);
  initial
  begin
    addr_o = 16'h0000;
    wr_data_o = 32'h00000000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // --------------
  // access tasks
  // --------------
  // data inverted once released, so stale values never look valid
  task wr(input [15:0] a, input [31:0] d);
  begin
    addr_o <= a;
    wr_data_o <= d;
    wr_o <= 1'b1;
    @(posedge clock_i);
    wr_o <= 1'b0;
    wr_data_o <= ~d;
  end
  endtask
  // data taken at the edge after the strobe, before it is cleared
  task rd(input [15:0] a, output [31:0] d);
  begin
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clock_i);
    rd_o <= 1'b0;
    @(posedge clock_i);
    d = rd_data_i;
  end
  endtask
endmodule

// file: mwm_top_sva.sv
// checker for the motion window monitor ports
// assumes one clock domain; bound to mwm_top below
`timescale 1ns/1ps
module mwm_top_chk
(
  input wire clock_i,
  input wire rst_i,
  input wire [15:0] addr_i,
  input wire [31:0] wr_data_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rd_data_o,
  input wire [15:0] status_word_o,
  input wire err_log_o,
  input wire irq_o
);
  reg fe_off;
  reg [2:0] age;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  // cycles since following window switched off, saturating
  always @(posedge clock_i or posedge rst_i)
    if (rst_i)
    begin
      fe_off <= 1'b0;
      age <= 3'h0;
    end
    else
    begin
      if (wr_i && addr_i == 16'h6065)
        fe_off <= wr_data_i == 32'hffffffff;
      age <= !fe_off ? 3'h0 : age + {2'h0, age != 3'h7};
    end
  // ----------
  // assertions
  // ----------
  a_rd_idle_zero: assert property (!rd_i |=> rd_data_o == 32'h0)
    else $error("read data not zero outside answer");
  a_fe_readback: assert property (
    wr_i && addr_i == 16'h6065 ##1 rd_i && addr_i == 16'h6065
    |=> rd_data_o == $past(wr_data_i, 2))
    else $error("following window readback wrong");
  a_short_upper: assert property (
    rd_i && (addr_i == 16'h6066 || addr_i == 16'h6068 ||
    addr_i == 16'h606d) |=> rd_data_o[31:16] == 16'h0)
    else $error("upper half of short register not zero");
  a_sw_spare: assert property ((status_word_o & 16'hdbff) == 16'h0)
    else $error("status word spare bit set");
  a_log_pulse: assert property (err_log_o |=> !err_log_o)
    else $error("error log pulse too long");
  a_log_follow: assert property (
    err_log_o |-> ##[0:2] status_word_o[13])
    else $error("error logged without following flag");
  a_reset_quiet: assert property (
    $fell(rst_i) |-> status_word_o == 16'h0 && !irq_o && !err_log_o)
    else $error("outputs not quiet after reset");
  a_fe_off_quiet: assert property (age == 3'h7 |-> !status_word_o[13])
    else $error("following flag while monitoring off");
  cover property (err_log_o);
  cover property ($rose(status_word_o[10]));
  cover property ($fell(irq_o));
endmodule
bind mwm_top mwm_top_chk i_mwm_top_chk (.clock_i(clock_i), .rst_i(rst_i),
  .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
  .rd_data_o(rd_data_o), .status_word_o(status_word_o),
  .err_log_o(err_log_o), .irq_o(irq_o));

// file: tb_top.sv
// self-checking testbench for the motion window monitor
// assumes the master model and a 10-cycle ms tick for short runs
`timescale 1ns/1ps
module tb_top;
  localparam logic [15:0] RA [0:9] = '{16'h6063, 16'h6064, 16'h6065,
    16'h6066, 16'h6067, 16'h6068, 16'h606b, 16'h606c, 16'h606d, 16'h0000};
  localparam logic [31:0] RV [0:9] = '{32'h0, 32'h0, 32'h100, 32'h64,
    32'ha, 32'h64, 32'h0, 32'h0, 32'h1e, 32'h0};
  reg clock_i = 1'b0;
  reg rst_i = 1'b1;
  reg homing = 1'b0;
  reg seen_log = 1'b0;
  reg [31:0] pinc = 32'h0, pusr = 32'h0, pdem = 32'h0, tpos = 32'h0;
  reg [31:0] spd = 32'h0, tspd = 32'h0, ramp = 32'h0, d;
  wire [15:0] addr, sw;
  wire [31:0] wdata, rdata;
  wire bus_wr, bus_rd, elog, irq;
  integer fails = 0, total_checks = 0, i;
  always #50 clock_i = ~clock_i;
  always @(posedge clock_i)
    if (elog === 1'b1)
      seen_log <= 1'b1;
  mwm_top #(.TICK_CYCLES(10)) i_mwm_top (.clock_i(clock_i), .rst_i(rst_i),
    .addr_i(addr), .wr_data_i(wdata), .wr_i(bus_wr), .rd_i(bus_rd),
    .rd_data_o(rdata), .pos_inc_i(pinc), .pos_user_i(pusr),
    .pos_demand_i(pdem), .target_pos_i(tpos), .speed_i(spd),
    .target_speed_i(tspd), .ramp_speed_i(ramp), .homing_done_i(homing),
    .status_word_o(sw), .err_log_o(elog), .irq_o(irq));
  mwm_master i_mwm_master (.clock_i(clock_i), .rd_data_i(rdata),
    .addr_o(addr), .wr_data_o(wdata), .wr_o(bus_wr), .rd_o(bus_rd));
  task end_sim;
  begin
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task put(input [15:0] a, input [31:0] v);
    i_mwm_master.wr(a, v);
  endtask
  task rc(input [15:0] a, input [31:0] e);
  begin
    i_mwm_master.rd(a, d);
    chk(d, e);
  end
  endtask
  // bounded wait; a bit that never arrives ends the run
  task wait_sw(input integer b, input v, input integer n);
    integer k;
  begin
    k = 0;
    while (sw[b] !== v && k < n)
    begin
      @(posedge clock_i);
      k = k + 1;
    end
    chk({31'h0, sw[b]}, {31'h0, v});
    if (sw[b] !== v)
      end_sim;
  end
  endtask
  task stay_sw(input integer b, input v, input integer n);
    repeat (n)
    begin
      @(posedge clock_i);
      chk({31'h0, sw[b]}, {31'h0, v});
    end
  endtask
  // -----
  // tests
  // -----
  initial
  begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    for (i = 0; i < 10; i = i + 1)
      rc(RA[i], RV[i]);
    $display("part 1 done");
    put(16'h6065, 32'h00001234);
    rc(16'h6065, 32'h00001234);
    put(16'h6063, 32'hffffffff);
    rc(16'h6063, 32'h0);
    put(16'h6066, 32'habcd0002);
    rc(16'h6066, 32'h00000002);
    pinc <= 32'h4d;
    ramp <= 32'hfffffffb;
    spd <= 32'h7;
    @(posedge clock_i);
    rc(16'h606b, 32'hfffffffb);
    rc(16'h606c, 32'h7);
    rc(16'h6063, 32'h4d);
    $display("part 2 done");
    put(16'h3700, 32'h1);
    @(posedge clock_i);
    put(16'h7002, 32'h1);
    pusr <= 32'h2000;
    stay_sw(13, 1'b0, 15);
    wait_sw(13, 1'b1, 40);
    repeat (2) @(posedge clock_i);
    chk({31'h0, seen_log}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    put(16'h7001, 32'h1);
    repeat (2) @(posedge clock_i);
    chk({31'h0, irq}, 32'h0);
    pusr <= 32'h0;
    wait_sw(13, 1'b0, 4);
    pusr <= 32'h1234;
    stay_sw(13, 1'b0, 50);
    put(16'h6065, 32'hffffffff);
    pusr <= 32'h7fff0000;
    stay_sw(13, 1'b0, 60);
    $display("part 3 done");
    pusr <= 32'h500;
    tpos <= 32'h505;
    put(16'h6068, 32'h1);
    @(posedge clock_i);
    put(16'h6060, 32'h1);
    wait_sw(10, 1'b1, 40);
    repeat (2) @(posedge clock_i);
    chk({31'h0, irq}, 32'h0);
    put(16'h7002, 32'h2);
    repeat (2) @(posedge clock_i);
    chk({31'h0, irq}, 32'h1);
    tpos <= 32'h50a;
    wait_sw(10, 1'b0, 4);
    tpos <= 32'h505;
    put(16'h6060, 32'h0);
    stay_sw(10, 1'b0, 40);
    put(16'h6060, 32'h7);
    wait_sw(10, 1'b1, 40);
    $display("part 4 done");
    tspd <= 32'h25;
    put(16'h6060, 32'h3);
    wait_sw(10, 1'b0, 4);
    stay_sw(10, 1'b0, 30);
    tspd <= 32'h24;
    wait_sw(10, 1'b1, 30);
    tspd <= 32'h25;
    put(16'h6067, 32'h0fffffff);
    @(posedge clock_i);
    put(16'h6060, 32'h1);
    wait_sw(10, 1'b0, 5);
    stay_sw(10, 1'b0, 40);
    $display("part 5 done");
    pusr <= 32'h600;
    homing <= 1'b1;
    @(posedge clock_i);
    homing <= 1'b0;
    rc(16'h6064, 32'h0);
    rc(16'h6063, 32'h4d);
    pusr <= 32'h603;
    @(posedge clock_i);
    rc(16'h6064, 32'h3);
    $display("part 6 done");
    end_sim;
  end
endmodule
